// File: logic/mcufc_pkg.sv
// Shared constants and carriers for the flag-clear and branch execution unit.
// Assumes a single 20 MHz core clock; one instruction word per machine cycle.
package mcufc_pkg;

    // ****************************************
    // Widths and depths
    // ****************************************
    localparam int PC_W    = 11;
    localparam int NIB_W   = 4;
    localparam int MEM_AW  = 7;
    localparam int MEM_D   = 128;
    localparam int DIV_W   = 14;
    localparam int WDT_W   = 8;
    localparam int SP_W    = 3;
    localparam int STK_D   = 8;
    localparam int EVF_W   = 8;
    localparam int ST_W    = 4;
    localparam int RA_W    = 4;
    localparam int RD_W    = 16;
    // Divider bits that wrap once every 1024 clocks.
    localparam int DIV_SLOW_W = 10;

    // ****************************************
    // Opcodes and field positions
    // ****************************************
    localparam logic [4:0] OP_NOP      = 5'h00;
    localparam logic [4:0] OP_AND_WB   = 5'h01;
    localparam logic [4:0] OP_CALL     = 5'h02;
    localparam logic [4:0] OP_CLR_CF   = 5'h03;
    localparam logic [4:0] OP_CLR_DIV  = 5'h04;
    localparam logic [4:0] OP_CLR_EVF  = 5'h05;
    localparam logic [4:0] OP_CLR_PMF  = 5'h06;
    localparam logic [4:0] OP_CLR_PCS  = 5'h07;
    localparam logic [4:0] OP_CLR_SER  = 5'h08;
    localparam logic [4:0] OP_CLR_WDT  = 5'h09;
    localparam logic [4:0] OP_DEC      = 5'h0a;
    localparam logic [4:0] OP_INTERRUPT_DISABLE_OP  = 5'h0b;
    localparam logic [4:0] OP_DECREMENT_SKIP_NONZERO_OP    = 5'h0c;
    localparam logic [4:0] OP_EN_INT   = 5'h0d;
    localparam int IMM_HI = 7;
    localparam int IMM_LO = 4;
    localparam int WR_HI  = 3;
    localparam int PMF_CLR_BIT = 3;
    localparam logic [EVF_W-1:0] EVF_RSVD = 8'h08;
    localparam logic [NIB_W-1:0] LOW_CLR = 4'h0;

    // ****************************************
    // Event flag bits
    // ****************************************
    localparam int EV_DIV = 0;
    localparam int EV_T0  = 1;
    localparam int EV_CHG = 2;
    localparam int EV_INT = 4;
    localparam int EV_RX  = 5;
    localparam int EV_TX  = 6;
    localparam int EV_T1  = 7;

    // ****************************************
    // Register map and status bits
    // ****************************************
    localparam logic [RA_W-1:0] REG_STATUS  = 4'h0;
    localparam logic [RA_W-1:0] REG_MASK    = 4'h1;
    localparam logic [RA_W-1:0] REG_CORE    = 4'h2;
    localparam logic [RA_W-1:0] REG_EVENT   = 4'h3;
    localparam logic [RA_W-1:0] REG_CONTROL = 4'h4;
    localparam logic [RA_W-1:0] REG_PC      = 4'h5;
    localparam logic [RA_W-1:0] REG_TIMERS  = 4'h6;
    localparam int ST_EVENT = 0;
    localparam int ST_SKIP  = 1;
    localparam int ST_CALL  = 2;
    localparam int ST_WDT   = 3;
    localparam int CTL_IE   = 0;
    localparam int CTL_PMF  = 1;
    localparam logic PMF_RST  = 1'b1;
    localparam logic IE_RST   = 1'b0;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [4:0]      op;
        logic [PC_W-1:0] arg;
    } mcufc_instr_t;

    typedef struct packed {
        logic t1Under;
        logic t0Under;
        logic rxDone;
        logic txDone;
    } mcufc_evin_t;

endpackage : mcufc_pkg

// File: logic/mcufc_core.sv
// Execution unit for the AND/CALL/flag-clear/decrement/interrupt-disable group.
// Assumes instruction words arrive synchronous to clk with a valid strobe and
// that event inputs are one-cycle pulses in the clk domain.
//
// Notes on behaviour
// - AND working register with immediate, result to it and accumulator, zero flag only.
// - Call pushes next address, then loads the 11-bit target into the counter.
// - Carry clear forces carry to zero, nothing else changes.
// - Divider clear zeroes the low four bits of the 14-bit divider only.
// - Event clear uses an 8-bit mask; ones clear, bit 3 reserved.
// - Flags 0, 1, 7 set by divider overflow, timer 0 and timer 1 underflow.
// - Flag 2 set on port change, flag 4 on falling interrupt pin edge.
// - Flag 5 set on serial receive done, flag 6 on transmit done.
// - Parameter clear bit 3 makes the watchdog run from clock divided by 1024.
// - Port status clear drops the change-detect status flag.
// - Serial status clear drops all serial status flags.
// - Watchdog clear zeroes the low four watchdog bits only.
// - Decrement memory nibble into memory and accumulator, update carry and zero.
// - Decrement operands are picked by a 7-bit direct address in the word, AND operands by a 4-bit register field.
// - Interrupt disable blocks acceptance from the next cycle until re-enabled.
// - Decrement-skip advances the counter by two when the result is non-zero.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
module mcufc_core (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Instruction fetch
    input  wire mcufc_pkg::mcufc_instr_t instrWord,
    input  wire logic                   instrValid,
    output logic [mcufc_pkg::PC_W-1:0]  pc,
    // Event sources
    input  wire mcufc_pkg::mcufc_evin_t evIn,
    input  wire logic [mcufc_pkg::NIB_W-1:0] changePort,
    input  wire logic                   extIntPin,
    // Register port
    input  wire logic [mcufc_pkg::RA_W-1:0] regAddr,
    input  wire logic [mcufc_pkg::RD_W-1:0] regWdata,
    input  wire logic                   regWrite,
    input  wire logic                   regRead,
    output logic [mcufc_pkg::RD_W-1:0]  regRdata,
    // Core state
    output logic [mcufc_pkg::NIB_W-1:0] accumulator,
    output logic                        carryFlag,
    output logic                        zeroFlag,
    output logic                        intEnable,
    output logic                        intPending,
    output logic                        irq
);
    import mcufc_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    // Hardware sets win over a clear arriving in the same cycle.
    function automatic logic [EVF_W-1:0] merge(input logic [EVF_W-1:0] cur,
                                               input logic [EVF_W-1:0] set,
                                               input logic [EVF_W-1:0] clr);
        merge = (cur & ~clr) | set;
    endfunction : merge

    function automatic logic isZero(input logic [NIB_W-1:0] v);
        isZero = (v == LOW_CLR);
    endfunction : isZero

    // ****************************************
    // State
    // ****************************************
    logic [NIB_W-1:0] dataMem [MEM_D];
    logic [PC_W-1:0]  stack [STK_D];
    logic [SP_W-1:0]  sp;
    logic [DIV_W-1:0] divider;
    logic [WDT_W-1:0] watchdog;
    logic [EVF_W-1:0] eventFlags;
    logic             paramFlag;
    logic             portChange;
    logic [1:0]       serialFlags;
    logic [NIB_W-1:0] portLast;
    logic             intLast;
    logic [ST_W-1:0]  status;
    logic [ST_W-1:0]  mask;

    // ****************************************
    // Decode
    // ****************************************
    logic [4:0]        op;
    logic              exec;
    logic [MEM_AW-1:0] memAddr;
    logic [NIB_W-1:0]  memVal;
    logic [NIB_W-1:0]  imm;
    logic [NIB_W-1:0]  andResult;
    logic [NIB_W-1:0]  decResult;
    logic [PC_W-1:0]   pcPlusOne;
    logic [PC_W-1:0]   pcPlusTwo;
    logic [PC_W-1:0]   callTarget;
    logic [PC_W-1:0]   retTop;
    logic              doAnd;
    logic              doDec;
    logic              skipTaken;
    logic              divOverflow;
    logic              slowTick;
    logic              wdtTick;
    logic              wdtOverflow;
    logic [EVF_W-1:0]  evfSet;
    logic [EVF_W-1:0]  evfClr;
    logic              chgSeen;

    assign op         = instrWord.op;
    assign exec       = instrValid;
    assign imm        = instrWord.arg[IMM_HI:IMM_LO];
    assign callTarget = instrWord.arg;
    assign memAddr    = (op == OP_AND_WB)
                      ? {{(MEM_AW-NIB_W){1'b0}}, instrWord.arg[WR_HI:0]}
                      : instrWord.arg[MEM_AW-1:0];
    assign memVal     = dataMem[memAddr];
    assign andResult  = memVal & imm;
    assign decResult  = memVal - NIB_W'(1);
    assign pcPlusOne  = pc + PC_W'(1);
    assign pcPlusTwo  = pc + PC_W'(2);
    assign retTop     = stack[sp - SP_W'(1)];
    assign doAnd      = exec && op == OP_AND_WB;
    assign doDec      = exec && (op == OP_DEC || op == OP_DECREMENT_SKIP_NONZERO_OP);
    assign skipTaken  = exec && op == OP_DECREMENT_SKIP_NONZERO_OP && !isZero(decResult);
    assign divOverflow = &divider;
    assign slowTick   = &divider[DIV_SLOW_W-1:0];
    // Flag clear selects the 1024 tap; flag set uses the full divider wrap.
    assign wdtTick    = paramFlag ? divOverflow : slowTick;
    assign wdtOverflow = wdtTick && &watchdog;
    assign chgSeen    = changePort != portLast;

    always_comb begin
        evfSet         = '0;
        evfSet[EV_DIV] = divOverflow;
        evfSet[EV_T0]  = evIn.t0Under;
        evfSet[EV_T1]  = evIn.t1Under;
        evfSet[EV_CHG] = chgSeen;
        evfSet[EV_INT] = intLast && !extIntPin;
        evfSet[EV_RX]  = evIn.rxDone;
        evfSet[EV_TX]  = evIn.txDone;
        evfClr         = '0;
        if (exec && op == OP_CLR_EVF) begin
            evfClr = instrWord.arg[EVF_W-1:0] & ~EVF_RSVD;
        end
    end

    // ****************************************
    // Program counter and return stack
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc <= '0;
            sp <= '0;
        end else if (exec) begin
            if (op == OP_CALL) begin
                stack[sp] <= pcPlusOne;
                sp        <= sp + SP_W'(1);
                pc        <= callTarget;
            end else if (skipTaken) begin
                pc <= pcPlusTwo;
            end else begin
                pc <= pcPlusOne;
            end
        end
    end

    // ****************************************
    // Data memory write-back
    // ****************************************
    always_ff @(posedge clk) begin
        if (doAnd) begin
            dataMem[memAddr] <= andResult;
        end else if (doDec) begin
            dataMem[memAddr] <= decResult;
        end
    end

    // ****************************************
    // Accumulator and flags
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            accumulator <= '0;
            carryFlag   <= 1'b0;
            zeroFlag    <= 1'b0;
        end else if (doAnd) begin
            accumulator <= andResult;
            zeroFlag    <= isZero(andResult);
        end else if (doDec) begin
            accumulator <= decResult;
            // Carry means no borrow, as with an add of all ones.
            carryFlag   <= !isZero(memVal);
            zeroFlag    <= isZero(decResult);
        end else if (exec && op == OP_CLR_CF) begin
            carryFlag <= 1'b0;
        end
    end

    // ****************************************
    // Divider and watchdog
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divider <= '0;
        end else if (exec && op == OP_CLR_DIV) begin
            divider <= {divider[DIV_W-1:NIB_W], LOW_CLR};
        end else begin
            divider <= divider + DIV_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog <= '0;
        end else if (exec && op == OP_CLR_WDT) begin
            watchdog <= {watchdog[WDT_W-1:NIB_W], LOW_CLR};
        end else if (wdtTick) begin
            watchdog <= watchdog + WDT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            paramFlag <= PMF_RST;
        end else if (exec && op == OP_CLR_PMF && instrWord.arg[PMF_CLR_BIT]) begin
            paramFlag <= 1'b0;
        end else if (regWrite && regAddr == REG_CONTROL) begin
            paramFlag <= regWdata[CTL_PMF];
        end
    end

    // ****************************************
    // Event and port status flags
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portLast <= '0;
            intLast  <= 1'b1;
        end else begin
            portLast <= changePort;
            intLast  <= extIntPin;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eventFlags <= '0;
        end else begin
            eventFlags <= merge(eventFlags, evfSet, evfClr);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portChange  <= 1'b0;
            serialFlags <= '0;
        end else begin
            if (chgSeen) begin
                portChange <= 1'b1;
            end else if (exec && op == OP_CLR_PCS) begin
                portChange <= 1'b0;
            end
            if (exec && op == OP_CLR_SER) begin
                serialFlags <= {evIn.rxDone, evIn.txDone};
            end else begin
                serialFlags <= serialFlags | {evIn.rxDone, evIn.txDone};
            end
        end
    end

    // ****************************************
    // Interrupt enable and acceptance
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intEnable <= IE_RST;
        end else if (exec && op == OP_INTERRUPT_DISABLE_OP) begin
            intEnable <= 1'b0;
        end else if (exec && op == OP_EN_INT) begin
            intEnable <= 1'b1;
        end else if (regWrite && regAddr == REG_CONTROL) begin
            intEnable <= regWdata[CTL_IE];
        end
    end

    // Registered from the enable and the decoded disable, so a disable gates the very next cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intPending <= 1'b0;
        end else begin
            intPending <= intEnable && !(exec && op == OP_INTERRUPT_DISABLE_OP)
                          && |eventFlags;
        end
    end

    // ****************************************
    // Register port, status and interrupt line
    // ****************************************
    logic [ST_W-1:0] stSet;
    logic            anyUnmasked;

    always_comb begin
        stSet           = '0;
        stSet[ST_EVENT] = |evfSet;
        stSet[ST_SKIP]  = skipTaken;
        stSet[ST_CALL]  = exec && op == OP_CALL;
        stSet[ST_WDT]   = wdtOverflow;
    end

    assign anyUnmasked = |(status & mask);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= '0;
        end else if (regRead && regAddr == REG_STATUS) begin
            status <= stSet;
        end else begin
            status <= status | stSet;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask <= '0;
        end else if (regWrite && regAddr == REG_MASK) begin
            mask <= regWdata[ST_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= anyUnmasked;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= '0;
        end else if (regRead) begin
            unique case (regAddr)
                REG_STATUS:  regRdata <= RD_W'(status);
                REG_MASK:    regRdata <= RD_W'(mask);
                REG_CORE:    regRdata <= RD_W'({zeroFlag, carryFlag, accumulator});
                REG_EVENT:   regRdata <= RD_W'({serialFlags, portChange, eventFlags});
                REG_CONTROL: regRdata <= RD_W'({paramFlag, intEnable});
                REG_PC:      regRdata <= RD_W'(pc);
                REG_TIMERS:  regRdata <= RD_W'({watchdog, divider[NIB_W-1:0]});
                default:     regRdata <= '0;
            endcase
        end else begin
            regRdata <= '0;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_and_writeback: assert property (@(posedge clk) disable iff (!rst_n)
        doAnd |=> accumulator == $past(andResult) && zeroFlag == isZero(accumulator)
                  && carryFlag == $past(carryFlag))
        else $error("AND result or flags wrong");

    chk_call_target: assert property (@(posedge clk) disable iff (!rst_n)
        exec && op == OP_CALL |=> pc == $past(callTarget) && retTop == $past(pcPlusOne))
        else $error("Call target or pushed address wrong");

    chk_carry_clear: assert property (@(posedge clk) disable iff (!rst_n)
        exec && op == OP_CLR_CF |=> !carryFlag && $stable(accumulator))
        else $error("Carry not cleared");

    chk_div_low_clear: assert property (@(posedge clk) disable iff (!rst_n)
        exec && op == OP_CLR_DIV |=> divider[NIB_W-1:0] == LOW_CLR
            && divider[DIV_W-1:NIB_W] == $past(divider[DIV_W-1:NIB_W]))
        else $error("Divider clear touched upper bits");

    chk_evf_mask_clear: assert property (@(posedge clk) disable iff (!rst_n)
        exec && op == OP_CLR_EVF |=> (eventFlags & $past(evfClr)) == ($past(evfSet) & $past(evfClr)))
        else $error("Event flag not cleared by mask");

    chk_evf_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
        |evfSet |=> (eventFlags & $past(evfSet)) == $past(evfSet))
        else $error("Event lost");

    chk_wdt_low_clear: assert property (@(posedge clk) disable iff (!rst_n)
        exec && op == OP_CLR_WDT |=> watchdog[NIB_W-1:0] == LOW_CLR
            && watchdog[WDT_W-1:NIB_W] == $past(watchdog[WDT_W-1:NIB_W]))
        else $error("Watchdog clear touched upper bits");

    chk_dec_result: assert property (@(posedge clk) disable iff (!rst_n)
        doDec |=> accumulator == $past(decResult) && carryFlag == !isZero($past(memVal)))
        else $error("Decrement result or carry wrong");

    chk_skip_two: assert property (@(posedge clk) disable iff (!rst_n)
        skipTaken |=> pc == $past(pcPlusTwo))
        else $error("Skip did not advance by two");

    chk_int_inhibit: assert property (@(posedge clk) disable iff (!rst_n)
        exec && op == OP_INTERRUPT_DISABLE_OP |=> !intEnable && !intPending)
        else $error("Interrupt accepted after disable");

    chk_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
        anyUnmasked |=> irq)
        else $error("Interrupt line missed unmasked status");

endmodule : mcufc_core

// File: tb/mcufc_prog_mem.sv
// Program memory model that hands one instruction word to the core per fetch.
// Assumes the bench places each word at the counter value that will fetch it.
`timescale 1ns/10ps
module mcufc_prog_mem (
    // Fetch side
    input  wire logic [mcufc_pkg::PC_W-1:0] pc,
    output mcufc_pkg::mcufc_instr_t         instrWord
);
    import mcufc_pkg::*;
    mcufc_instr_t mem [2**PC_W];
    // Unloaded words read as no-operation, so a stray fetch only advances the counter.
    initial begin
        for (int i = 0; i < 2**PC_W; i++) mem[i] = '0;
    end
    assign instrWord = mem[pc];
endmodule : mcufc_prog_mem

// File: tb/mcu_flag_clear_and_branch_ops_tb.sv
// Self-checking bench for the flag-clear and branch execution unit.
// Assumes the program memory model above and a single 20 MHz clock.
`timescale 1ns/10ps
module mcu_flag_clear_and_branch_ops_tb;
    import mcufc_pkg::*;
    // ****************************************
    // Signals, model state and helpers
    // ****************************************
    logic             clk = 1'b0, rst_n = 1'b0, instrValid = 1'b0, extIntPin = 1'b1;
    logic             regWrite = 1'b0, regRead = 1'b0;
    logic             carryFlag, zeroFlag, intEnable, intPending, irq;
    logic [PC_W-1:0]  pc;
    logic [NIB_W-1:0] changePort = 4'h0, accumulator;
    logic [RA_W-1:0]  regAddr = 4'h0;
    logic [RD_W-1:0]  regWdata = 16'h0000, regRdata, rdv, evAcc;
    logic [15:0]      seed = 16'h2eb8;
    mcufc_instr_t     instrWord;
    mcufc_evin_t      evIn = '0;
    int               n_mismatch, total_checks, expPc, expCf, mem [16];
    logic [15:0]      evExp [6] = '{16'h0080, 16'h0002, 16'h0420, 16'h0240, 16'h0104, 16'h0010};

    mcufc_prog_mem mcufc_prog_mem_inst (.pc(pc), .instrWord(instrWord));
    mcufc_core mcufc_core_inst (.clk(clk), .rst_n(rst_n), .instrWord(instrWord),
        .instrValid(instrValid), .pc(pc), .evIn(evIn), .changePort(changePort),
        .extIntPin(extIntPin), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .accumulator(accumulator),
        .carryFlag(carryFlag), .zeroFlag(zeroFlag), .intEnable(intEnable),
        .intPending(intPending), .irq(irq));

    always #25 clk = ~clk;

    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic exec(logic [4:0] code, logic [10:0] arg);
        @(posedge clk);
        mcufc_prog_mem_inst.mem[pc] <= {code, arg};
        instrValid <= 1'b1;
        @(posedge clk);
        instrValid <= 1'b0;
        #1;
    endtask : exec

    task automatic op(logic [4:0] code, logic [10:0] arg);
        exec(code, arg);
        expPc++;
    endtask : op

    task automatic rd(logic [3:0] a);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 rdv = regRdata;
    endtask : rd

    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic core_chk(int a);
        chk("accumulator", 16'(a), 16'(accumulator));
        chk("zeroFlag", 16'(a == 0), 16'(zeroFlag));
        chk("carryFlag", 16'(expCf), 16'(carryFlag));
        chk("pc", 16'(expPc), 16'(pc));
    endtask : core_chk

    task automatic and_op(int r, logic [3:0] imm);
        mem[r] = mem[r] & imm;
        op(OP_AND_WB, {3'b000, imm, 4'(r)});
        core_chk(mem[r]);
    endtask : and_op

    task automatic dec(int r, logic [4:0] code);
        int old;
        old = mem[r];
        mem[r] = (old + 15) % 16;
        expCf = int'(old != 0);
        exec(code, 11'(r));
        expPc += (code == OP_DECREMENT_SKIP_NONZERO_OP && mem[r] != 0) ? 2 : 1;
        core_chk(mem[r]);
    endtask : dec

    task automatic ev_chk(logic [15:0] e);
        rd(REG_EVENT);
        // Flag 0 follows the free-running divider, so it is left out of the compare.
        chk("event", e, rdv & 16'h07fe);
    endtask : ev_chk

    task automatic pulse(int k);
        @(posedge clk);
        if (k < 4) evIn <= mcufc_evin_t'(4'h8 >> k);
        else if (k == 4) changePort <= ~changePort;
        else extIntPin <= 1'b0;
        @(posedge clk);
        evIn <= '0;
        extIntPin <= 1'b1;
    endtask : pulse
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(REG_CONTROL);
        chk("control", 16'h0002, rdv);
        for (int r = 0; r < 16; r += 5) begin
            seed = lfsr(seed);
            and_op(r, 4'h0);
            dec(r, OP_DEC);
            and_op(r, seed[3:0]);
            while (mem[r] != 0) dec(r, OP_DECREMENT_SKIP_NONZERO_OP);
            op(OP_CLR_CF, 11'h000);
            expCf = 0;
            core_chk(mem[r]);
        end
        rd(REG_CORE);
        chk("core", 16'((mem[15] == 0) * 32 + expCf * 16 + mem[15]), rdv);
        op(OP_CLR_DIV, 11'h000);
        rd(REG_TIMERS);
        chk("divider", 16'h0001, rdv & 16'h000f);
        op(OP_CLR_WDT, 11'h000);
        rd(REG_TIMERS);
        chk("watchdog", 16'h0000, rdv & 16'h00f0);
        op(OP_CLR_PMF, 11'h007);
        rd(REG_CONTROL);
        chk("control", 16'h0002, rdv);
        op(OP_CLR_PMF, 11'h008);
        rd(REG_CONTROL);
        chk("control", 16'h0000, rdv);
        // Any 1024 consecutive clocks hold exactly one watchdog tick on the slow tap.
        rd(REG_TIMERS);
        evAcc = rdv >> 4;
        repeat (1022) @(posedge clk);
        rd(REG_TIMERS);
        chk("watchdog", (evAcc + 16'h0001) & 16'h00ff, rdv >> 4);
        evAcc = 16'h0000;
        for (int k = 0; k < 6; k++) begin
            evAcc |= evExp[k];
            pulse(k);
            ev_chk(evAcc);
        end
        op(OP_EN_INT, 11'h000);
        settle();
        chk("intPending", 16'h0001, 16'(intPending));
        op(OP_INTERRUPT_DISABLE_OP, 11'h000);
        chk("intEnable", 16'h0000, 16'(intEnable));
        settle();
        chk("intPending", 16'h0000, 16'(intPending));
        op(OP_CLR_EVF, 11'h008);
        ev_chk(evAcc);
        op(OP_CLR_EVF, 11'h0fe);
        ev_chk(evAcc & 16'h0700);
        op(OP_CLR_PCS, 11'h000);
        ev_chk(evAcc & 16'h0600);
        op(OP_CLR_SER, 11'h000);
        ev_chk(16'h0000);
        wr(REG_MASK, 16'h0004);
        rd(REG_MASK);
        chk("mask", 16'h0004, rdv);
        rd(REG_STATUS);
        settle();
        chk("irq", 16'h0000, 16'(irq));
        seed = lfsr(seed);
        expPc = int'(seed[10:0]);
        exec(OP_CALL, seed[10:0]);
        chk("pc", 16'(expPc), 16'(pc));
        rd(REG_PC);
        chk("pcReg", 16'(expPc), rdv);
        settle();
        chk("irq", 16'h0001, 16'(irq));
        wr(REG_MASK, 16'h0000);
        settle();
        chk("irq", 16'h0000, 16'(irq));
        wr(REG_MASK, 16'h0004);
        settle();
        chk("irq", 16'h0001, 16'(irq));
        rd(REG_STATUS);
        chk("status", 16'h0004, rdv & 16'h0004);
        settle();
        chk("irq", 16'h0000, 16'(irq));
        wr(REG_CONTROL, 16'h0001);
        rd(REG_CONTROL);
        chk("control", 16'h0001, rdv);
        chk("intEnable", 16'h0001, 16'(intEnable));
        rd(4'hf);
        chk("unmapped", 16'h0000, rdv);
        final_report();
    end

    // A hang is cut short at 20000 cycles, well past the roughly 1200 cycles the sequence needs.
    initial begin
        #(50 * 20000);
        n_mismatch++;
        final_report();
    end
endmodule : mcu_flag_clear_and_branch_ops_tb
